/* File: hdl/colour_gain_offset_regs.sv */
`timescale 1ns/10ps
module colour_gain_offset_regs
    import cgo_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    output logic [7:0] offset_code_o,
    output logic [7:0] gain_code_o,
    output logic [1:0] colour_select_o
);

    typedef struct packed {
        colour_set_t red;
        colour_set_t green;
        colour_set_t blue;
        colour_sel_t colour_select;
        wb_rsp_t rsp;
    } regs_state_t;

    regs_state_t state;
    regs_state_t next_state;
    wb_req_t req;
    colour_set_t active;
    logic access;
    logic wr_low;
    logic [31:0] rd_data;

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};
    assign access = req.cyc && req.stb && !state.rsp.ack;
    assign wr_low = access && req.we && req.sel[0];

    // Read mux; unmapped and broadcast addresses answer zero
    always_comb begin
        case (req.adr)
            ADDR_RED_OFFSET: rd_data = {24'h000000, state.red.offset};
            ADDR_GREEN_OFFSET: rd_data = {24'h000000, state.green.offset};
            ADDR_BLUE_OFFSET: rd_data = {24'h000000, state.blue.offset};
            ADDR_RED_GAIN: rd_data = {24'h000000, state.red.gain};
            ADDR_GREEN_GAIN: rd_data = {24'h000000, state.green.gain};
            ADDR_BLUE_GAIN: rd_data = {24'h000000, state.blue.gain};
            ADDR_SETUP: rd_data = {26'h0000000, state.colour_select, 4'h0};
            ADDR_ALL_OFFSET: rd_data = BROADCAST_READ;
            ADDR_ALL_GAIN: rd_data = BROADCAST_READ;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // Register writes and bus answer
    always_comb begin
        next_state = state;
        next_state.rsp.ack = access;
        next_state.rsp.dat = access ? rd_data : 32'h0000_0000;
        if (wr_low) begin
            case (req.adr)
                ADDR_RED_OFFSET: next_state.red.offset = req.dat[7:0];
                ADDR_GREEN_OFFSET: next_state.green.offset = req.dat[7:0];
                ADDR_BLUE_OFFSET: next_state.blue.offset = req.dat[7:0];
                ADDR_ALL_OFFSET: begin
                    next_state.red.offset = req.dat[7:0];
                    next_state.green.offset = req.dat[7:0];
                    next_state.blue.offset = req.dat[7:0];
                end
                ADDR_RED_GAIN: next_state.red.gain = req.dat[7:0];
                ADDR_GREEN_GAIN: next_state.green.gain = req.dat[7:0];
                ADDR_BLUE_GAIN: next_state.blue.gain = req.dat[7:0];
                ADDR_ALL_GAIN: begin
                    next_state.red.gain = req.dat[7:0];
                    next_state.green.gain = req.dat[7:0];
                    next_state.blue.gain = req.dat[7:0];
                end
                ADDR_SETUP: next_state.colour_select = colour_sel_t'(req.dat[SEL_MSB:SEL_LSB]);
                default: next_state.colour_select = state.colour_select;
            endcase
        end
        // Soft reset: any write, any byte lane
        if (access && req.we && req.adr == ADDR_SOFT_RESET) begin
            next_state.red = '{offset: OFFSET_RESET, gain: GAIN_RESET};
            next_state.green = '{offset: OFFSET_RESET, gain: GAIN_RESET};
            next_state.blue = '{offset: OFFSET_RESET, gain: GAIN_RESET};
            next_state.colour_select = colour_sel_t'(SEL_RESET);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state.red <= '{offset: OFFSET_RESET, gain: GAIN_RESET};
            state.green <= '{offset: OFFSET_RESET, gain: GAIN_RESET};
            state.blue <= '{offset: OFFSET_RESET, gain: GAIN_RESET};
            state.colour_select <= colour_sel_t'(SEL_RESET);
            state.rsp <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Routes the chosen colour set to the analogue stages
    colour_mux u_colour_mux (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .red_i(state.red),
        .green_i(state.green),
        .blue_i(state.blue),
        .sel_i(state.colour_select),
        .active_o(active)
    );

    assign wb_ack_o = state.rsp.ack;
    assign wb_dat_o = state.rsp.dat;
    assign offset_code_o = active.offset;
    assign gain_code_o = active.gain;
    assign colour_select_o = state.colour_select;

    ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held for two cycles");
    ack_timing_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("ack not one cycle after request");
    red_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_RED_OFFSET)
        |=> (state.red.offset == $past(wb_dat_i[7:0])))
        else $error("red offset write lost");
    bcast_offset_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_ALL_OFFSET)
        |=> (state.red.offset == $past(wb_dat_i[7:0]) && state.green.offset == $past(wb_dat_i[7:0])
             && state.blue.offset == $past(wb_dat_i[7:0])))
        else $error("broadcast offset not loaded");
    bcast_gain_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_ALL_GAIN)
        |=> (state.red.gain == $past(wb_dat_i[7:0]) && state.green.gain == $past(wb_dat_i[7:0])
             && state.blue.gain == $past(wb_dat_i[7:0])))
        else $error("broadcast gain not loaded");
    green_gain_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state.colour_select == SEL_GREEN) ##1 (state.colour_select == SEL_GREEN)
        |-> (gain_code_o == $past(state.green.gain)))
        else $error("green gain not presented");
    blue_gain_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state.colour_select == SEL_BLUE) ##1 (state.colour_select == SEL_BLUE)
        |-> (gain_code_o == $past(state.blue.gain)))
        else $error("blue gain not presented");
    red_gain_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state.colour_select == SEL_RED) ##1 (state.colour_select == SEL_RED)
        |-> (gain_code_o == $past(state.red.gain)))
        else $error("red gain not presented");
    soft_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && wb_we_i && wb_adr_i == ADDR_SOFT_RESET)
        |=> (state.red.offset == OFFSET_RESET && state.blue.gain == GAIN_RESET
             && state.colour_select == SEL_RED) ##2 (offset_code_o == OFFSET_RESET && gain_code_o == GAIN_RESET))
        else $error("soft reset did not restore defaults");
    sel_reg_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_SETUP)
        |=> (colour_select_o == $past(wb_dat_i[SEL_MSB:SEL_LSB])))
        else $error("colour select not written");

    green_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && wb_we_i && wb_sel_i[0]
            && wb_adr_i == ADDR_GREEN_OFFSET)
        |=> (state.green.offset == $past(wb_dat_i[7:0])))
        else $error("green offset write lost");

    blue_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && wb_we_i && wb_sel_i[0]
            && wb_adr_i == ADDR_BLUE_OFFSET)
        |=> (state.blue.offset == $past(wb_dat_i[7:0])))
        else $error("blue offset write lost");

    red_gain_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && wb_we_i && wb_sel_i[0]
            && wb_adr_i == ADDR_RED_GAIN)
        |=> (state.red.gain == $past(wb_dat_i[7:0])))
        else $error("red gain write lost");

    green_gain_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && wb_we_i && wb_sel_i[0]
            && wb_adr_i == ADDR_GREEN_GAIN)
        |=> (state.green.gain == $past(wb_dat_i[7:0])))
        else $error("green gain write lost");

    blue_gain_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && wb_we_i && wb_sel_i[0]
            && wb_adr_i == ADDR_BLUE_GAIN)
        |=> (state.blue.gain == $past(wb_dat_i[7:0])))
        else $error("blue gain write lost");

    red_lane_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && wb_we_i && !wb_sel_i[0]
            && wb_adr_i == ADDR_RED_OFFSET)
        |=> $stable(state.red.offset))
        else $error("red offset changed without lane");

    green_lane_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && wb_we_i && !wb_sel_i[0]
            && wb_adr_i == ADDR_GREEN_OFFSET)
        |=> $stable(state.green.offset))
        else $error("green offset changed without lane");

    blue_lane_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && wb_we_i && !wb_sel_i[0]
            && wb_adr_i == ADDR_BLUE_OFFSET)
        |=> $stable(state.blue.offset))
        else $error("blue offset changed without lane");

    red_gain_lane_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && wb_we_i && !wb_sel_i[0]
            && wb_adr_i == ADDR_RED_GAIN)
        |=> $stable(state.red.gain))
        else $error("red gain changed without lane");

    green_gain_lane_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && wb_we_i && !wb_sel_i[0]
            && wb_adr_i == ADDR_GREEN_GAIN)
        |=> $stable(state.green.gain))
        else $error("green gain changed without lane");

    blue_gain_lane_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && wb_we_i && !wb_sel_i[0]
            && wb_adr_i == ADDR_BLUE_GAIN)
        |=> $stable(state.blue.gain))
        else $error("blue gain changed without lane");

    bcast_off_lane_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && wb_we_i && !wb_sel_i[0]
            && wb_adr_i == ADDR_ALL_OFFSET)
        |=> $stable(state.red.offset))
        else $error("broadcast offset applied without lane");

    bcast_gain_lane_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && wb_we_i && !wb_sel_i[0]
            && wb_adr_i == ADDR_ALL_GAIN)
        |=> $stable(state.blue.gain))
        else $error("broadcast gain applied without lane");

    soft_green_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && wb_we_i
            && wb_adr_i == ADDR_SOFT_RESET)
        |=> (state.green.offset == OFFSET_RESET && state.green.gain == GAIN_RESET))
        else $error("soft reset missed green set");

    soft_mixed_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && wb_we_i
            && wb_adr_i == ADDR_SOFT_RESET)
        |=> (state.red.gain == GAIN_RESET && state.blue.offset == OFFSET_RESET))
        else $error("soft reset missed red gain or blue offset");

    soft_lane_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && wb_we_i && !wb_sel_i[0]
            && wb_adr_i == ADDR_SOFT_RESET)
        |=> (state.green.gain == GAIN_RESET && state.red.offset == OFFSET_RESET))
        else $error("soft reset ignored without lane");

    read_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !wb_ack_o
        |-> (wb_dat_o == 32'h0000_0000))
        else $error("read data outside ack");

    bcast_off_rd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && !wb_we_i
            && wb_adr_i == ADDR_ALL_OFFSET)
        |=> (wb_dat_o == BROADCAST_READ))
        else $error("broadcast offset read not fixed");

    bcast_gain_rd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && !wb_we_i
            && wb_adr_i == ADDR_ALL_GAIN)
        |=> (wb_dat_o == BROADCAST_READ))
        else $error("broadcast gain read not fixed");

    red_rd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && !wb_we_i
            && wb_adr_i == ADDR_RED_OFFSET)
        |=> (wb_dat_o == {24'h000000, $past(state.red.offset)}))
        else $error("red offset read wrong");

    green_rd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && !wb_we_i
            && wb_adr_i == ADDR_GREEN_OFFSET)
        |=> (wb_dat_o == {24'h000000, $past(state.green.offset)}))
        else $error("green offset read wrong");

    blue_rd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && !wb_we_i
            && wb_adr_i == ADDR_BLUE_OFFSET)
        |=> (wb_dat_o == {24'h000000, $past(state.blue.offset)}))
        else $error("blue offset read wrong");

    red_gain_rd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && !wb_we_i
            && wb_adr_i == ADDR_RED_GAIN)
        |=> (wb_dat_o == {24'h000000, $past(state.red.gain)}))
        else $error("red gain read wrong");

    green_gain_rd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && !wb_we_i
            && wb_adr_i == ADDR_GREEN_GAIN)
        |=> (wb_dat_o == {24'h000000, $past(state.green.gain)}))
        else $error("green gain read wrong");

    blue_gain_rd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && !wb_we_i
            && wb_adr_i == ADDR_BLUE_GAIN)
        |=> (wb_dat_o == {24'h000000, $past(state.blue.gain)}))
        else $error("blue gain read wrong");

    sel_rd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && !wb_we_i
            && wb_adr_i == ADDR_SETUP)
        |=> (wb_dat_o[SEL_MSB:SEL_LSB] == $past(state.colour_select)))
        else $error("colour select read wrong");

    rsvd_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state.colour_select == SEL_RSVD)
            ##1 (state.colour_select == SEL_RSVD)
        |-> ($stable(offset_code_o) && $stable(gain_code_o)))
        else $error("reserved select moved outputs");

    red_off_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state.colour_select == SEL_RED)
            ##1 (state.colour_select == SEL_RED)
        |-> (offset_code_o == $past(state.red.offset)))
        else $error("red offset not presented");

    green_off_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state.colour_select == SEL_GREEN)
            ##1 (state.colour_select == SEL_GREEN)
        |-> (offset_code_o == $past(state.green.offset)))
        else $error("green offset not presented");

    blue_off_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state.colour_select == SEL_BLUE)
            ##1 (state.colour_select == SEL_BLUE)
        |-> (offset_code_o == $past(state.blue.offset)))
        else $error("blue offset not presented");

endmodule // colour_gain_offset_regs

/* File: hdl/cgo_pkg.sv */
package cgo_pkg;

    // Register word offsets (byte addresses)
    localparam logic [5:0] ADDR_RED_OFFSET = 6'h00;
    localparam logic [5:0] ADDR_GREEN_OFFSET = 6'h04;
    localparam logic [5:0] ADDR_BLUE_OFFSET = 6'h08;
    localparam logic [5:0] ADDR_ALL_OFFSET = 6'h0C;
    localparam logic [5:0] ADDR_RED_GAIN = 6'h10;
    localparam logic [5:0] ADDR_GREEN_GAIN = 6'h14;
    localparam logic [5:0] ADDR_BLUE_GAIN = 6'h18;
    localparam logic [5:0] ADDR_ALL_GAIN = 6'h1C;
    localparam logic [5:0] ADDR_SETUP = 6'h20;
    localparam logic [5:0] ADDR_SOFT_RESET = 6'h24;

    // Field positions in the setup register
    localparam int SEL_LSB = 4;
    localparam int SEL_MSB = 5;

    // Values after reset
    localparam logic [7:0] OFFSET_RESET = 8'h80;
    localparam logic [7:0] GAIN_RESET = 8'h00;
    localparam logic [1:0] SEL_RESET = 2'h0;

    // Value returned by the write-only broadcast locations
    localparam logic [31:0] BROADCAST_READ = 32'h0000_0000;

    typedef enum logic [1:0] {
        SEL_RED = 2'b00,
        SEL_GREEN = 2'b01,
        SEL_BLUE = 2'b10,
        SEL_RSVD = 2'b11
    } colour_sel_t;

    typedef struct packed {
        logic [7:0] offset;
        logic [7:0] gain;
    } colour_set_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [5:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;

endpackage

/* File: hdl/colour_mux.sv */
`timescale 1ns/10ps
module colour_mux
    import cgo_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire colour_set_t red_i,
    input wire colour_set_t green_i,
    input wire colour_set_t blue_i,
    input wire colour_sel_t sel_i,
    output colour_set_t active_o
);

    typedef struct packed {
        colour_set_t active;
    } mux_state_t;

    mux_state_t state;
    mux_state_t next_state;

    // Reserved code keeps the last active set
    always_comb begin
        next_state = state;
        case (sel_i)
            SEL_RED: next_state.active = red_i;
            SEL_GREEN: next_state.active = green_i;
            SEL_BLUE: next_state.active = blue_i;
            default: next_state.active = state.active;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state.active.offset <= OFFSET_RESET;
            state.active.gain <= GAIN_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign active_o = state.active;

    mux_red_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (sel_i == SEL_RED) |=> (active_o == $past(red_i)))
        else $error("red set not routed");
    mux_green_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (sel_i == SEL_GREEN) |=> (active_o == $past(green_i)))
        else $error("green set not routed");
    mux_blue_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (sel_i == SEL_BLUE) |=> (active_o == $past(blue_i)))
        else $error("blue set not routed");

endmodule // colour_mux

/* File: sim/wb_host.sv */
`timescale 1ns/10ps
module wb_host (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [5:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    logic timed_out;
    initial begin
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
        timed_out = 1'h0;
    end
    // One classic cycle; the request stands until ack is seen high or 64 clocks pass
    task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc_o <= 1'h1;
        stb_o <= 1'h1;
        we_o <= w;
        adr_o <= a;
        sel_o <= s;
        dat_o <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_i !== 1'h1 && n < 64);
        q = dat_i;
        if (n >= 64) timed_out = 1'h1;
        cyc_o <= 1'h0;
        stb_o <= 1'h0;
        we_o <= 1'h0;
        adr_o <= ~a;
        dat_o <= ~d;
    endtask
endmodule // wb_host

/* File: sim/tb.sv */
`timescale 1ns/10ps
module tb;
    import cgo_pkg::*;
    logic clk_i, rst_i, cyc, stb, we, ack;
    logic [5:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    logic [7:0] off_o, gain_o;
    logic [1:0] csel_o;
    int error_cnt, samples_checked;
    colour_gain_offset_regs uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
        .offset_code_o(off_o), .gain_code_o(gain_o), .colour_select_o(csel_o));
    wb_host host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
        .adr_o(adr), .sel_o(sel), .dat_o(wdat));
    initial begin
        clk_i = 1'h0;
        forever #4 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
        host.xfer(1'h1, a, d, s, q);
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
        host.xfer(1'h0, a, 32'h0, 4'hF, q);
        chk(q, exp);
    endtask
    // Active outputs after the register path settles
    task automatic out_chk(input logic [7:0] o, input logic [7:0] g, input logic [1:0] c);
        repeat (3) @(posedge clk_i);
        chk({14'h0, csel_o, gain_o, off_o}, {14'h0, c, g, o});
    endtask
    task automatic defaults_chk;
        for (int i = 0; i < 3; i++) begin
            rd_chk(ADDR_RED_OFFSET + 6'(4 * i), 32'h80);
            rd_chk(ADDR_RED_GAIN + 6'(4 * i), 32'h0);
        end
        out_chk(8'h80, 8'h00, 2'h0);
    endtask
    always @(posedge clk_i) begin
        if (host.timed_out === 1'h1) begin
            error_cnt++;
            report_and_stop();
        end
    end
    initial begin
        error_cnt = 0;
        samples_checked = 0;
        rst_i = 1'h1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        wr(ADDR_SOFT_RESET, 32'h0);
        defaults_chk();
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_RED_OFFSET + 6'(4 * i), 32'h11 * (i + 1));
            wr(ADDR_RED_GAIN + 6'(4 * i), 32'hC1 + i);
        end
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_SETUP, 32'(i) << 4);
            out_chk(8'(8'h11 * (i + 1)), 8'(8'hC1 + i), 2'(i));
        end
        wr(ADDR_SETUP, 32'h30);
        out_chk(8'h33, 8'hC3, 2'h3);
        wr(ADDR_RED_OFFSET, 32'h77, 4'hE);
        rd_chk(ADDR_RED_OFFSET, 32'h11);
        wr(6'h3C, 32'hFF);
        rd_chk(6'h3C, 32'h0);
        wr(ADDR_ALL_OFFSET, 32'h5A);
        wr(ADDR_ALL_GAIN, 32'hA5);
        for (int i = 0; i < 3; i++) begin
            rd_chk(ADDR_RED_OFFSET + 6'(4 * i), 32'h5A);
            rd_chk(ADDR_RED_GAIN + 6'(4 * i), 32'hA5);
        end
        rd_chk(ADDR_ALL_OFFSET, 32'h0);
        rd_chk(ADDR_ALL_GAIN, 32'h0);
        wr(ADDR_SETUP, 32'h20);
        out_chk(8'h5A, 8'hA5, 2'h2);
        wr(ADDR_SOFT_RESET, 32'h0, 4'h0);
        defaults_chk();
        report_and_stop();
    end
endmodule // tb
